/* design/blc_params.svh */
`ifndef BLC_PARAMS_SVH
`define BLC_PARAMS_SVH
// How it works
// RQ1: setting the line 1 flush bit flushes it if dirty; hardware clears bit.
// RQ2: setting the line 0 flush bit flushes it if dirty; hardware clears bit.
// RQ3: advice enable set fills a line from dequeued buffer start; clear ignores.
// RQ4: immediate-ack mode acknowledges advice at once, dropping it if busy.
// RQ5: hold-ack mode acknowledges advice only after latching it. Code: with advice enable clear it acks at once without latching.
// RQ6: ping-pong enable confines long sequential runs to two alternating lines.
// RQ7: collision-lock disable keeps collisions from locking the memory controller.
// RQ8: auto flush writes back a line after sequential writes hit its last two words.
// RQ9: force bit runs predictive fill on every access.
// RQ10: force bit clear runs predictive fill on streaming accesses only.
// RQ11: threshold all ones fills on first streaming access anywhere in line.
// RQ12: threshold 3F fills on streaming access to offsets 2 through 7.
// RQ13: threshold 03 fills on streaming access to offsets 6 or 7.
// RQ14: threshold zero disables predictive fills.
// RQ15: dirty line idle for timeout ticks of 240 ns is flushed.
// RQ16: timeout zero disables timed flushes.
// RQ17: four 32-byte lines, each tagged; tag compare selects the line.
// RQ18: each dirty line counts idle ticks; access restarts, flush clears it.

// ==================== register map
`define BLC_CTRL_ADDR 12'h000
`define BLC_STAT_ADDR 12'h004
`define BLC_CTRL_RESET 32'h2000_0000
`define BLC_CTRL_WMASK 32'h03FC_FFFF
// ==================== control fields
`define BLC_FL1_BIT 25
`define BLC_FL0_BIT 24
`define BLC_ADV_EN_BIT 23
`define BLC_ADV_HOLD_BIT 22
`define BLC_PP_BIT 21
`define BLC_NOLOCK_BIT 20
`define BLC_AUTO_BIT 19
`define BLC_FORCE_BIT 18
`define BLC_THR_HI 15
`define BLC_THR_LO 8
`define BLC_TMO_HI 7
`define BLC_TMO_LO 0
// ==================== timing
`define BLC_TICK_NS 240
`define BLC_CLK_NS 4
`define BLC_TICK_CYC ((`BLC_TICK_NS + `BLC_CLK_NS - 1) / `BLC_CLK_NS)
`endif

/* design/blc_pkg.sv */
package blc_pkg;
  typedef enum logic [1:0] {
    BLC_IDLE = 2'b00,
    BLC_WAIT = 2'b01,
    BLC_DONE = 2'b11
  } blc_fstate_t;
endpackage : blc_pkg

/* design/blc_tick.sv */
`timescale 1ns/1ps
`include "blc_params.svh"
module blc_tick (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // tick out
  output logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } blc_tick_st_t;
  blc_tick_st_t s_q, s_d;
  localparam logic [7:0] LAST = 8'(`BLC_TICK_CYC - 1);
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == LAST) begin
      s_d.cnt = 8'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
endmodule : blc_tick

/* design/blc_top.sv */
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "blc_params.svh"
module blc_top
  import blc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // cache access
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_write,
  input wire logic acc_stream,
  // receive queue entity advice
  input wire logic adv_valid,
  input wire logic [31:0] adv_addr,
  output logic adv_ack,
  // memory side
  output logic fill_req,
  output logic [31:0] fill_addr,
  output logic flush_req,
  output logic [1:0] flush_line,
  input wire logic flush_done,
  input wire logic collision,
  output logic mc_lock
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic aw_got;
    logic [11:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] valid;
    logic [3:0] dirty;
    logic [26:0] tag0, tag1, tag2, tag3;
    logic [7:0] idle0, idle1, idle2, idle3;
    logic [1:0] victim;
    logic pp;
    logic [1:0] last_line;
    logic [2:0] last_word;
    logic last_wr;
    blc_fstate_t fst;
    logic [1:0] fline;
    logic fill;
    logic [31:0] faddr;
    logic [27:0] pend;
    logic adv_busy;
    logic [31:0] adv_q;
    logic lock;
  } blc_st_t;
  blc_st_t s_q, s_d;
  logic tick;
  blc_tick u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );
  // ==================== helpers
  // mask bit 7-k enables word k, so the low bits cover the end of the line
  function automatic logic thr_hit(input logic [7:0] thr, input logic [2:0] wd);
    logic [7:0] bit_sel;
    bit_sel = 8'h80 >> wd;
    return (thr & bit_sel) != 8'h00;
  endfunction : thr_hit
  function automatic logic [7:0] idle_next(input logic [7:0] c, input logic dty,
                                           input logic hit, input logic tk);
    if (!dty || hit) begin
      return 8'h00;
    end
    return (tk && c != 8'hFF) ? c + 8'h01 : c;
  endfunction : idle_next
  logic [26:0] tags [4];
  logic [7:0] idles [4];
  logic [3:0] hit;
  logic [1:0] hit_idx;
  logic any_hit;
  logic [2:0] word;
  logic [7:0] thr;
  logic [7:0] tmo;
  logic pred_ok;
  logic fire;
  logic [31:0] wmask;
  always_comb begin
    tags[0] = s_q.tag0;
    tags[1] = s_q.tag1;
    tags[2] = s_q.tag2;
    tags[3] = s_q.tag3;
    idles[0] = s_q.idle0;
    idles[1] = s_q.idle1;
    idles[2] = s_q.idle2;
    idles[3] = s_q.idle3;
    hit_idx = 2'h0;
    // RQ17 tag compare
    for (int i = 0; i < 4; i++) begin
      hit[i] = s_q.valid[i] && tags[i] == acc_addr[31:5];
      if (hit[i]) begin
        hit_idx = 2'(i);
      end
    end
  end
  assign any_hit = hit != 4'h0;
  assign word = acc_addr[4:2];
  assign thr = s_q.ctrl[`BLC_THR_HI:`BLC_THR_LO];
  assign tmo = s_q.ctrl[`BLC_TMO_HI:`BLC_TMO_LO];
  // RQ9 all accesses when forced
  // RQ10 otherwise streaming only
  assign pred_ok = s_q.ctrl[`BLC_FORCE_BIT] || acc_stream;
  assign wmask = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}}, {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
  // ==================== next state
  always_comb begin
    logic [1:0] alloc;
    logic [7:0] nidle [4];
    logic [3:0] expired;
    logic adv_fill;
    logic [26:0] ntag;
    logic [31:0] wr_set;
    s_d = s_q;
    alloc = s_q.victim;
    expired = 4'h0;
    adv_fill = 1'b0;
    ntag = acc_addr[31:5];
    wr_set = 32'h0000_0000;
    s_d.fill = 1'b0;
    fire = 1'b0;
    // axi write path
    if (s_awvalid && !s_q.aw_got) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_awaddr;
    end
    if (s_wvalid && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_wdata;
      s_d.wstrb = s_wstrb;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = 2'b00;
      if (s_q.awaddr == `BLC_CTRL_ADDR) begin
        wr_set = s_q.wdata & wmask & `BLC_CTRL_WMASK;
        s_d.ctrl = (s_q.ctrl & ~(wmask & `BLC_CTRL_WMASK))
                 | (s_q.wdata & wmask & `BLC_CTRL_WMASK);
      end else begin
        s_d.bresp = 2'b10;
      end
    end
    if (s_q.bvalid && s_bready) begin
      s_d.bvalid = 1'b0;
    end
    // axi read path
    if (s_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = 2'b00;
      if (s_araddr == `BLC_CTRL_ADDR) begin
        s_d.rdata = s_q.ctrl;
      end else if (s_araddr == `BLC_STAT_ADDR) begin
        s_d.rdata = {20'h00000, s_q.lock, s_q.pp, s_q.fst == BLC_IDLE, 1'b0, s_q.dirty, s_q.valid};
      end else begin
        s_d.rdata = 32'h0000_0000;
        s_d.rresp = 2'b10;
      end
    end else if (s_q.rvalid && s_rready) begin
      s_d.rvalid = 1'b0;
    end
    // RQ18 idle counters per line
    for (int i = 0; i < 4; i++) begin
      nidle[i] = idle_next(idles[i], s_q.dirty[i], acc_valid && hit[i], tick);
      // RQ15 timeout reached
      // RQ16 zero disables
      expired[i] = s_q.dirty[i] && tmo != 8'h00 && idles[i] >= tmo;
    end
    // ==================== cache access
    if (acc_valid) begin
      if (any_hit) begin
        alloc = hit_idx;
      end else begin
        // RQ6 ping-pong between two lines for sequential runs
        if (s_q.ctrl[`BLC_PP_BIT] && acc_stream) begin
          alloc = {1'b0, ~s_q.pp};
          s_d.pp = ~s_q.pp;
        end
        s_d.valid[alloc] = 1'b1;
        s_d.dirty[alloc] = 1'b0;
        s_d.victim = s_q.victim + 2'h1;
        s_d.fill = 1'b1;
        s_d.faddr = {acc_addr[31:5], 5'h00};
      end
      if (acc_write) begin
        s_d.dirty[alloc] = 1'b1;
      end
      nidle[alloc] = 8'h00;
      // RQ11 RQ12 RQ13 RQ14 threshold mask on word offset
      if (pred_ok && thr_hit(thr, word)) begin
        s_d.pend = {1'b1, acc_addr[31:5] + 27'h1};
      end
      // RQ8 sequential write over last two words
      fire = s_q.ctrl[`BLC_AUTO_BIT] && acc_write && word == 3'h7 && s_q.last_wr
           && s_q.last_word == 3'h6 && s_q.last_line == alloc;
      s_d.last_line = alloc;
      s_d.last_word = word;
      s_d.last_wr = acc_write;
    end
    if (s_d.pend[27] && !s_d.fill) begin
      s_d.pend[27] = 1'b0;
      s_d.fill = 1'b1;
      s_d.faddr = {s_d.pend[26:0], 5'h00};
    end
    // RQ3 advice fills buffer start
    if (adv_valid && s_q.ctrl[`BLC_ADV_EN_BIT] && !s_q.adv_busy && !s_d.fill) begin
      s_d.adv_busy = 1'b1;
      s_d.adv_q = adv_addr;
    end
    if (s_q.adv_busy && !s_d.fill) begin
      adv_fill = 1'b1;
      s_d.adv_busy = 1'b0;
      s_d.fill = 1'b1;
      s_d.faddr = {s_q.adv_q[31:5], 5'h00};
      ntag = s_q.adv_q[31:5];
      s_d.valid[s_q.victim] = 1'b1;
      s_d.dirty[s_q.victim] = 1'b0;
      s_d.victim = s_q.victim + 2'h1;
    end
    if ((acc_valid && !any_hit) || adv_fill) begin
      case (adv_fill ? s_q.victim : alloc)
        2'h0: s_d.tag0 = ntag;
        2'h1: s_d.tag1 = ntag;
        2'h2: s_d.tag2 = ntag;
        default: s_d.tag3 = ntag;
      endcase
    end
    // ==================== flush sequencer
    case (s_q.fst)
      BLC_IDLE: begin
        // RQ2 flush line 0
        if (s_q.ctrl[`BLC_FL0_BIT]) begin
          s_d.fline = 2'h0;
          s_d.fst = s_q.dirty[0] ? BLC_WAIT : BLC_DONE;
        // RQ1 flush line 1
        end else if (s_q.ctrl[`BLC_FL1_BIT]) begin
          s_d.fline = 2'h1;
          s_d.fst = s_q.dirty[1] ? BLC_WAIT : BLC_DONE;
        end else if (fire) begin
          s_d.fline = alloc;
          s_d.fst = BLC_WAIT;
        end else begin
          for (int i = 3; i >= 0; i--) begin
            if (expired[i]) begin
              s_d.fline = 2'(i);
              s_d.fst = BLC_WAIT;
            end
          end
        end
      end
      BLC_WAIT: begin
        if (flush_done) begin
          s_d.dirty[s_q.fline] = acc_valid && acc_write && alloc == s_q.fline;
          nidle[s_q.fline] = 8'h00;
          s_d.fst = BLC_DONE;
        end
      end
      BLC_DONE: begin
        // RQ1 RQ2 self-clear on completion
        if (s_q.fline == 2'h0 && !wr_set[`BLC_FL0_BIT]) begin
          s_d.ctrl[`BLC_FL0_BIT] = 1'b0;
        end
        if (s_q.fline == 2'h1 && !wr_set[`BLC_FL1_BIT]) begin
          s_d.ctrl[`BLC_FL1_BIT] = 1'b0;
        end
        s_d.fst = BLC_IDLE;
      end
      default: s_d.fst = BLC_IDLE;
    endcase
    s_d.idle0 = nidle[0];
    s_d.idle1 = nidle[1];
    s_d.idle2 = nidle[2];
    s_d.idle3 = nidle[3];
    // RQ7 collision lock unless disabled
    if (collision && !s_q.ctrl[`BLC_NOLOCK_BIT]) begin
      s_d.lock = 1'b1;
    end else if (s_q.ctrl[`BLC_NOLOCK_BIT]) begin
      s_d.lock = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ctrl <= `BLC_CTRL_RESET;
      s_q.fst <= BLC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end
  // ==================== outputs
  assign s_awready = !s_q.aw_got;
  assign s_wready = !s_q.w_got;
  assign s_bvalid = s_q.bvalid;
  assign s_bresp = s_q.bresp;
  assign s_arready = !s_q.rvalid;
  assign s_rvalid = s_q.rvalid;
  assign s_rdata = s_q.rdata;
  assign s_rresp = s_q.rresp;
  // RQ4 immediate ack when hold mode is off
  // RQ5 hold ack until latched, or ack at once while advice enable is clear
  assign adv_ack = adv_valid && (!s_q.ctrl[`BLC_ADV_HOLD_BIT] ||
                   (s_q.ctrl[`BLC_ADV_EN_BIT] && !s_q.adv_busy && !s_d.fill) ||
                   !s_q.ctrl[`BLC_ADV_EN_BIT]);
  assign fill_req = s_q.fill;
  assign fill_addr = s_q.faddr;
  assign flush_req = s_q.fst == BLC_WAIT;
  assign flush_line = s_q.fline;
  assign mc_lock = s_q.lock;
  // ==================== checks
  // RQ2 self-clear follows completion
  chk_fl0_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.fst == BLC_DONE && s_q.fline == 2'h0 |=> !s_q.ctrl[`BLC_FL0_BIT]) // RQ2
    else $error("flush 0 bit not cleared");
  chk_fl1_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.fst == BLC_DONE && s_q.fline == 2'h1 |=> !s_q.ctrl[`BLC_FL1_BIT]) // RQ1
    else $error("flush 1 bit not cleared");
  chk_adv_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
    !s_q.ctrl[`BLC_ADV_EN_BIT] && !s_q.adv_busy |=> !s_q.adv_busy) // RQ3
    else $error("advice taken while disabled");
  chk_adv_immed: assert property (@(posedge aclk) disable iff (!aresetn)
    adv_valid && !s_q.ctrl[`BLC_ADV_HOLD_BIT] |-> adv_ack) // RQ4
    else $error("advice not acked at once");
  chk_nolock: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.ctrl[`BLC_NOLOCK_BIT] |=> !mc_lock) // RQ7
    else $error("locked with lock disabled");
  chk_tmo_off: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.fst == BLC_IDLE && tmo == 8'h00 && !fire && s_q.ctrl[25:24] == 2'b00
    |=> s_q.fst == BLC_IDLE) // RQ16
    else $error("timed flush while disabled");
  chk_thr_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    acc_valid && any_hit && thr == 8'h00 && !s_q.adv_busy && !s_q.pend[27] |=> !fill_req) // RQ14
    else $error("predictive fill with zero threshold");
  chk_fill_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    !acc_valid && !s_q.adv_busy && !s_q.pend[27] |=> !fill_req) // RQ10
    else $error("fill without cause");
  cov_flush: cover property (@(posedge aclk) s_q.fst == BLC_WAIT ##1 s_q.fst == BLC_DONE);
  cov_adv: cover property (@(posedge aclk) adv_valid && adv_ack && s_q.ctrl[`BLC_ADV_HOLD_BIT]);
  cov_pp: cover property (@(posedge aclk) acc_valid && acc_stream && s_q.ctrl[`BLC_PP_BIT]);
endmodule : blc_top

/* verif/blc_mem_model.sv */
`timescale 1ns/1ps
// ==================== memory side responder
module blc_mem_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // flush handshake
  input wire logic flush_req,
  input wire logic slow,
  output logic flush_done
);
  int cnt;
  logic busy_q;
  // one done pulse per request; busy skips the edge where the request is still seen
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      busy_q <= 1'b0;
      flush_done <= 1'b0;
    end else begin
      flush_done <= !busy_q && flush_req && cnt >= (slow ? 20 : 1);
    end
    if (!aresetn) begin
      cnt <= 0;
    end else if (busy_q) begin
      busy_q <= 1'b0;
    end else if (flush_req) begin
      if (cnt >= (slow ? 20 : 1)) begin
        busy_q <= 1'b1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : blc_mem_model

/* verif/bus_cache_line_control_bench.sv */
`timescale 1ns/1ps
`include "blc_params.svh"
module bus_cache_line_control_bench;
  import blc_pkg::*;
  localparam int TICK = `BLC_TICK_CYC;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, acc_valid, acc_write, acc_stream;
  logic adv_valid, adv_ack, fill_req, flush_req, flush_done, collision, mc_lock, slow;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, acc_addr, adv_addr, fill_addr, rd, a;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, flush_line, rsp, wrsp, fl_seen;
  logic [7:0] thr;
  logic [2:0] w;
  logic st, frc;
  int num_errors, check_count, cycles, n, nf, lat, fl_cnt;
  logic [7:0] thr_tab [4] = '{8'h00, 8'hFF, 8'h3F, 8'h03};

  blc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_write(acc_write), .acc_stream(acc_stream),
    .adv_valid(adv_valid), .adv_addr(adv_addr), .adv_ack(adv_ack), .fill_req(fill_req),
    .fill_addr(fill_addr), .flush_req(flush_req), .flush_line(flush_line),
    .flush_done(flush_done), .collision(collision), .mc_lock(mc_lock));
  blc_mem_model u_mem (.aclk(aclk), .aresetn(aresetn), .flush_req(flush_req), .slow(slow),
    .flush_done(flush_done));

  // ==================== clock and timeout
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // flush monitor: last line flushed and flush cycles seen
  always @(posedge aclk) begin
    if (flush_req === 1'b1) begin
      fl_seen <= flush_line;
      fl_cnt <= fl_cnt + 1;
    end
  end

  // ==================== helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t ns: %s", $time, what);
    end
  endtask : chk
  task automatic axi_wr(input logic [11:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    s_awaddr <= ad;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      k++;
    end while (s_bvalid !== 1'b1 && k < 200);
    wrsp = s_bresp;
    if (s_bvalid !== 1'b1) num_errors++;
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] ad);
    int k;
    k = 0;
    s_araddr <= ad;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      k++;
    end while (s_rvalid !== 1'b1 && k < 200);
    if (s_rvalid !== 1'b1) num_errors++;
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd
  // predictive fills fetch the following line; demand fills are not counted
  task automatic access(input logic [31:0] ad, input logic wr, input logic s);
    acc_addr <= ad;
    acc_write <= wr;
    acc_stream <= s;
    acc_valid <= 1'b1;
    @(posedge aclk);
    acc_valid <= 1'b0;
    nf = 0;
    repeat (8) begin
      @(posedge aclk);
      if (fill_req === 1'b1 && fill_addr[31:5] === ad[31:5] + 27'h1) nf++;
    end
  endtask : access
  task automatic advise(input logic [31:0] ad);
    adv_addr <= ad;
    adv_valid <= 1'b1;
    lat = 0;
    do begin
      @(posedge aclk);
      lat++;
    end while (adv_ack !== 1'b1 && lat < 50);
    adv_valid <= 1'b0;
    nf = 0;
    repeat (6) begin
      @(posedge aclk);
      if (fill_req === 1'b1 && fill_addr[31:5] === ad[31:5]) nf++;
    end
  endtask : advise
  function automatic logic want_fill(logic [7:0] t, logic [2:0] wd, logic s, logic f);
    if (!s && !f) return 1'b0;
    if (t == 8'hFF) return 1'b1;
    return t[3'd7 - wd];
  endfunction : want_fill
  function automatic logic [31:0] rnd_line();
    return $urandom & 32'h7FFF_FFE0;
  endfunction : rnd_line
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  // ==================== tests
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, acc_valid} = '0;
    {acc_write, acc_stream, adv_valid, collision, slow} = '0;
    {s_awaddr, s_araddr, s_wdata, acc_addr, adv_addr} = '0;
    s_wstrb = 4'hF;
    void'($urandom(83));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(`BLC_CTRL_ADDR);
    chk(rd, `BLC_CTRL_RESET, "control reset value");
    axi_wr(`BLC_CTRL_ADDR, 32'h00E7_AB00);
    chk({30'h0, wrsp}, 32'h0, "control write response");
    axi_rd(`BLC_CTRL_ADDR);
    chk(rd, 32'h20E4_AB00, "control readback");
    axi_rd(12'hFFC);
    chk({30'h0, rsp}, 32'h2, "unmapped read response");
    axi_wr(12'hFFC, 32'h0000_0000);
    chk({30'h0, wrsp}, 32'h2, "unmapped write response");
    $display("test registers done");
    axi_wr(`BLC_CTRL_ADDR, 32'h0000_0000);
    advise(rnd_line());
    chk(lat, 1, "advice ack not immediate");
    chk(nf, 0, "ignored advice filled");
    axi_wr(`BLC_CTRL_ADDR, 32'h0080_0000);
    advise(rnd_line());
    chk(lat, 1, "enabled advice ack not immediate");
    axi_wr(`BLC_CTRL_ADDR, 32'h00C0_0000);
    advise(rnd_line());
    chk(nf, 1, "held advice not used");
    $display("test advice done");
    for (int i = 0; i < 24; i++) begin
      thr = thr_tab[i % 4];
      w = (i < 8) ? 3'(i) : 3'($urandom_range(0, 7));
      st = (i < 12) ? 1'b1 : 1'($urandom_range(0, 1));
      frc = (i < 12) ? 1'b0 : 1'($urandom_range(0, 1));
      axi_wr(`BLC_CTRL_ADDR, {13'h0, frc, 2'b00, thr, 8'h00});
      access(rnd_line() | {27'h0, w, 2'b00}, 1'b0, st);
      chk(nf > 0, want_fill(thr, w, st, frc), "predictive fill decision");
    end
    $display("test threshold done");
    for (int b = 24; b < 26; b++) begin
      slow <= 1'($urandom_range(0, 1));
      axi_wr(`BLC_CTRL_ADDR, 32'h1 << `BLC_PP_BIT);
      access(rnd_line(), 1'b1, 1'b1);
      access(rnd_line(), 1'b1, 1'b1);
      axi_wr(`BLC_CTRL_ADDR, 32'h1 << b);
      n = 0;
      do begin
        axi_rd(`BLC_CTRL_ADDR);
        n++;
      end while (rd[b] && n < 40);
      chk(rd[b], 1'b0, "flush bit not cleared");
      chk(fl_seen, b - 24, "flushed line number");
      axi_rd(`BLC_STAT_ADDR);
      chk({rd[7:6], rd[b - 20]}, 32'h0, "dirty lines after ping-pong flush");
    end
    $display("test line flush done");
    axi_wr(`BLC_CTRL_ADDR, 32'h0000_0001);
    repeat (4 * TICK) @(posedge aclk);
    axi_wr(`BLC_CTRL_ADDR, 32'h0000_0002);
    access(rnd_line(), 1'b1, 1'b0);
    n = 9;
    while (flush_req !== 1'b1 && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    chk(n >= TICK && n <= 2 * TICK + 8, 1'b1, "timed flush moment");
    repeat (30) @(posedge aclk);
    axi_wr(`BLC_CTRL_ADDR, 32'h0000_0000);
    access(rnd_line(), 1'b1, 1'b0);
    n = 0;
    repeat (4 * TICK) begin
      @(posedge aclk);
      if (flush_req === 1'b1) n++;
    end
    chk(n, 0, "timed flush while disabled");
    $display("test timed flush done");
    axi_wr(`BLC_CTRL_ADDR, 32'h0000_0000);
    collision <= 1'b1;
    @(posedge aclk);
    collision <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(mc_lock, 1'b1, "no lock on collision");
    axi_wr(`BLC_CTRL_ADDR, 32'h0010_0000);
    collision <= 1'b1;
    @(posedge aclk);
    collision <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(mc_lock, 1'b0, "lock despite disable");
    $display("test collision done");
    axi_wr(`BLC_CTRL_ADDR, 32'h1 << `BLC_AUTO_BIT);
    a = rnd_line();
    access(a | 32'h0000_0018, 1'b1, 1'b0);
    n = fl_cnt;
    access(a | 32'h0000_001C, 1'b1, 1'b0);
    chk(fl_cnt > n, 1'b1, "no flush after last two words written");
    $display("test auto flush done");
    wrap_up();
  end
endmodule : bus_cache_line_control_bench
